// file: rtl/pm_reset_pkg.sv
// Package for the port multiplier reset and soft-reset responder
package pm_reset_pkg;

  // Register map, word addresses as byte offsets
  localparam logic [3:0] ADDR_CTRL      = 4'h0;
  localparam logic [3:0] ADDR_STATUS    = 4'h4;
  localparam logic [3:0] ADDR_PORT_EN   = 4'h8;
  localparam logic [3:0] ADDR_EVENTS    = 4'hC;

  // Field positions
  localparam int CTRL_DEV_RESET_BIT     = 0;
  localparam int CTRL_SIG_ACK_BIT       = 1;
  localparam int DEVCTL_SOFT_RESET_BIT  = 2;

  // Reset values
  localparam logic [7:0] PORT_EN_RESET  = 8'h00;
  localparam logic [7:0] EVENTS_RESET   = 8'h00;

  // Reset sequence length in clock cycles
  localparam int RESET_SEQ_CYCLES       = 16;
  localparam logic [4:0] RESET_SEQ_LAST = 5'h0F;

  // Signature field values
  localparam logic [7:0] SIG_ERROR      = 8'h00;
  localparam logic [7:0] SIG_COUNT_LO   = 8'h01;
  localparam logic [7:0] SIG_COUNT_HI   = 8'h00;
  localparam logic [7:0] SIG_LBA0       = 8'h01;
  localparam logic [7:0] SIG_LBA1       = 8'h00;
  localparam logic [7:0] SIG_LBA2       = 8'h69;
  localparam logic [7:0] SIG_LBA3       = 8'h00;
  localparam logic [7:0] SIG_LBA4       = 8'h96;
  localparam logic [7:0] SIG_LBA5       = 8'h00;
  localparam logic [7:0] SIG_DEVICE     = 8'h00;
  // Busy 0, ready 1, fault 0, bit4 0, data request 0, bits 2..1 0, error 0
  localparam logic [7:0] SIG_STATUS     = 8'h40;

  typedef enum logic [3:0] {
    ST_NO_COMM   = 4'b0001,
    ST_HOTPLUG   = 4'b0010,
    ST_SOFT_WAIT = 4'b0100,
    ST_SIG_SEND  = 4'b1000
  } pm_state_t;

  // Register Host to Device FIS as seen on the control port
  typedef struct packed {
    logic       valid;
    logic       is_command;
    logic [7:0] command;
    logic [7:0] device_control;
  } h2d_fis_t;

  // Register Device to Host FIS fields
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] error;
    logic [7:0] device;
    logic [7:0] lba5;
    logic [7:0] lba4;
    logic [7:0] lba3;
    logic [7:0] lba2;
    logic [7:0] lba1;
    logic [7:0] lba0;
    logic [7:0] count_hi;
    logic [7:0] count_lo;
  } d2h_fis_t;

  localparam logic [7:0] CMD_DEVICE_RESET = 8'h08;

endpackage

// file: rtl/pin_sync.sv
// Three flop synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module pin_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_state_t;

  sync_state_t q;
  sync_state_t d;

  // Level follows only when the second and third stage agree
  always_comb begin
    d     = q;
    d.s1  = pin;
    d.s2  = q.s1;
    d.s3  = q.s2;
    if (q.s2 == q.s3) begin
      d.lvl = q.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.lvl;
endmodule

// file: rtl/sig_fis_rom.sv
// Registered source of the signature register FIS
`timescale 1ns/1ps
module sig_fis_rom (
  input  wire logic                  clk,
  input  wire logic                  rst,
  output pm_reset_pkg::d2h_fis_t     fis
);
  pm_reset_pkg::d2h_fis_t q;
  pm_reset_pkg::d2h_fis_t d;

  // Constant fields, registered so the data output is a flop
  always_comb begin
    d          = q;
    d.status   = pm_reset_pkg::SIG_STATUS;   // RQ11
    d.error    = pm_reset_pkg::SIG_ERROR;    // RQ10
    d.device   = pm_reset_pkg::SIG_DEVICE;
    d.lba5     = pm_reset_pkg::SIG_LBA5;
    d.lba4     = pm_reset_pkg::SIG_LBA4;
    d.lba3     = pm_reset_pkg::SIG_LBA3;
    d.lba2     = pm_reset_pkg::SIG_LBA2;
    d.lba1     = pm_reset_pkg::SIG_LBA1;
    d.lba0     = pm_reset_pkg::SIG_LBA0;
    d.count_hi = pm_reset_pkg::SIG_COUNT_HI;
    d.count_lo = pm_reset_pkg::SIG_COUNT_LO;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign fis = q;
endmodule

// file: rtl/pm_reset_ctrl.sv
// Port multiplier reset, power-up and control-port soft-reset handling
//
// Contract
// RQ1: Power-up enters no-comm state, then proceeds to hot-plug handling.
// RQ2: Entering no-comm clears all internal state and resets hardware.
// RQ3: Entering no-comm loads register reset values; all device ports disabled. On COMRESET the events register loads its reset value with bit 0 set.
// RQ4: COMRESET before first COMINIT abandons power-up, does COMRESET actions.
// RQ5: Any host COMRESET enters no-comm, clears state, disables device ports.
// RQ6: Soft reset or DEVICE RESET never resets the device.
// RQ7: Host resets the port multiplier only with COMRESET.
// RQ8: Host soft reset is two FISes: soft-reset bit set, then cleared.
// RQ9: After set FIS, wait for cleared FIS, then send signature FIS.
// RQ10: Signature carries fixed error, count and LBA bytes.
// RQ11: Signature status: only device ready set, other named flags clear.
// RQ12: Soft reset causes no reset action, only the signature FIS.
// RQ13: DEVICE RESET to control port is an unsupported command.
// RQ14: Repeated set FISes keep waiting; exactly one signature after clear.
//
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
module pm_reset_ctrl (
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Host link events
  input  wire logic                   comreset_pin,
  output logic                        cominit_req,
  input  wire logic                   cominit_sent,
  input  wire pm_reset_pkg::h2d_fis_t h2d_fis,
  output logic                        sig_fis_valid,
  input  wire logic                   sig_fis_ready,
  output pm_reset_pkg::d2h_fis_t      sig_fis,
  output logic                        cmd_abort,
  output logic                        hw_reset,
  output logic [7:0]                  port_enable,
  output logic                        in_no_comm,
  // Avalon-MM slave
  input  wire logic [3:0]             avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest
);

  typedef struct packed {
    pm_reset_pkg::pm_state_t state;
    logic [4:0]              seq_cnt;
    logic                    cominit_done;
    logic                    sig_valid;
    logic                    abort;
    logic [7:0]              port_en;
    logic [7:0]              events;
    logic                    bus_ack;
    logic [31:0]             rdata;
    logic                    comreset_prev;
  } ctrl_state_t;

  ctrl_state_t q;
  ctrl_state_t d;

  logic                   comreset_lvl;
  logic                   comreset_rise;
  logic                   soft_set_fis;
  logic                   soft_clr_fis;
  logic                   dev_reset_cmd;
  pm_reset_pkg::d2h_fis_t rom_fis;

  // COMRESET arrives from the link's out-of-band detector, so it is a pin
  pin_sync u_comreset_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   (comreset_pin),
    .level (comreset_lvl)
  );

  sig_fis_rom u_sig_rom (
    .clk (clk),
    .rst (rst),
    .fis (rom_fis)
  );

  assign comreset_rise = comreset_lvl && !q.comreset_prev;
  // Control FISes carry the soft reset bit in device control
  assign soft_set_fis  = h2d_fis.valid && !h2d_fis.is_command
                         && h2d_fis.device_control[pm_reset_pkg::DEVCTL_SOFT_RESET_BIT];
  assign soft_clr_fis  = h2d_fis.valid && !h2d_fis.is_command
                         && !h2d_fis.device_control[pm_reset_pkg::DEVCTL_SOFT_RESET_BIT];
  assign dev_reset_cmd = h2d_fis.valid && h2d_fis.is_command
                         && (h2d_fis.command == pm_reset_pkg::CMD_DEVICE_RESET);

  // Next-state logic for the sequencer and the register file
  always_comb begin
    d               = q;
    d.comreset_prev = comreset_lvl;
    d.abort         = 1'b0;
    d.bus_ack       = 1'b0;

    case (q.state)
      pm_reset_pkg::ST_NO_COMM: begin
        // Hold hardware in reset while the clearing sequence runs
        d.port_en   = pm_reset_pkg::PORT_EN_RESET;       // RQ3
        d.sig_valid = 1'b0;                              // RQ2
        if (q.seq_cnt == pm_reset_pkg::RESET_SEQ_LAST) begin
          d.state   = pm_reset_pkg::ST_HOTPLUG;          // RQ1
        end else begin
          d.seq_cnt = q.seq_cnt + 5'h01;
        end
      end
      pm_reset_pkg::ST_HOTPLUG: begin
        if (soft_set_fis) begin
          d.state = pm_reset_pkg::ST_SOFT_WAIT;          // RQ9
        end
      end
      pm_reset_pkg::ST_SOFT_WAIT: begin
        // Further set FISes simply keep us here
        if (soft_clr_fis) begin
          d.state     = pm_reset_pkg::ST_SIG_SEND;       // RQ14
          d.sig_valid = 1'b1;                            // RQ9
        end
      end
      pm_reset_pkg::ST_SIG_SEND: begin
        // One signature only; set FISes are ignored until it is taken
        if (sig_fis_ready) begin
          d.sig_valid = 1'b0;                            // RQ14
          d.state     = pm_reset_pkg::ST_HOTPLUG;
          d.events[1] = 1'b1;
        end
      end
      default: begin
        d.state = pm_reset_pkg::ST_NO_COMM;
      end
    endcase

    // COMINIT tracking: the power-up sequence ends with the first COMINIT
    if (cominit_sent) begin
      d.cominit_done = 1'b1;
    end

    // Device reset command is refused, never acted on as a reset
    if (dev_reset_cmd) begin
      d.abort     = 1'b1;                                // RQ13 RQ6
      d.events[2] = 1'b1;
    end

    // Register bus: one wait cycle, answer on the second
    if ((avs_read || avs_write) && !q.bus_ack) begin
      d.bus_ack = 1'b1;
      d.rdata   = 32'h0000_0000;
      if (avs_address == pm_reset_pkg::ADDR_CTRL) begin
        d.rdata = 32'h0000_0000;
      end else if (avs_address == pm_reset_pkg::ADDR_STATUS) begin
        d.rdata = {22'h0, q.cominit_done, q.sig_valid, 4'(q.state), q.seq_cnt[3:0]};
      end else if (avs_address == pm_reset_pkg::ADDR_PORT_EN) begin
        d.rdata = {24'h000000, q.port_en};
      end else if (avs_address == pm_reset_pkg::ADDR_EVENTS) begin
        d.rdata = {24'h000000, q.events};
      end
    end

    // Writes land only in the accepting cycle, while waitrequest is low
    if (avs_write && q.bus_ack) begin
      if (avs_address == pm_reset_pkg::ADDR_PORT_EN && q.state != pm_reset_pkg::ST_NO_COMM) begin
        d.port_en = avs_writedata[7:0];
      end else if (avs_address == pm_reset_pkg::ADDR_EVENTS) begin
        // Write one to clear; a same-cycle hardware set still wins below
        d.events = q.events & ~avs_writedata[7:0];
      end
    end

    // Hardware sets of event flags win over a software clear
    if (q.state == pm_reset_pkg::ST_SIG_SEND && sig_fis_ready) begin
      d.events[1] = 1'b1;
    end
    if (dev_reset_cmd) begin
      d.events[2] = 1'b1;
    end

    // COMRESET overrides the sequencer, port, COMINIT and event updates, including an unfinished power-up
    if (comreset_rise) begin
      d.state     = pm_reset_pkg::ST_NO_COMM;            // RQ5 RQ4
      d.seq_cnt   = 5'h00;                               // RQ2
      d.sig_valid = 1'b0;                                // RQ2
      d.port_en   = pm_reset_pkg::PORT_EN_RESET;         // RQ3
      d.cominit_done = 1'b0;
      d.events    = pm_reset_pkg::EVENTS_RESET | 8'h01;
    end
  end

  // State register; power-up reset lands in the no-comm state
  always_ff @(posedge clk) begin
    if (rst) begin
      q               <= '0;
      q.state         <= pm_reset_pkg::ST_NO_COMM;       // RQ1
      q.port_en       <= pm_reset_pkg::PORT_EN_RESET;    // RQ3
      q.events        <= pm_reset_pkg::EVENTS_RESET;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign hw_reset        = (q.state == pm_reset_pkg::ST_NO_COMM);   // RQ2
  assign in_no_comm      = (q.state == pm_reset_pkg::ST_NO_COMM);
  assign cominit_req     = (q.state == pm_reset_pkg::ST_HOTPLUG) && !q.cominit_done;
  assign sig_fis_valid   = q.sig_valid;
  assign sig_fis         = rom_fis;                                  // RQ10 RQ11 RQ12
  assign cmd_abort       = q.abort;
  assign port_enable     = q.port_en;
  assign avs_readdata    = q.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !q.bus_ack;

endmodule

// file: bench/pm_reset_ctrl_assertions.sv
// Port-level checks for the reset and soft-reset controller
`timescale 1ns/1ps
module pm_reset_ctrl_assertions (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic                   comreset_pin,
  input wire logic                   cominit_req,
  input wire logic                   cominit_sent,
  input wire pm_reset_pkg::h2d_fis_t h2d_fis,
  input wire logic                   sig_fis_valid,
  input wire logic                   sig_fis_ready,
  input wire pm_reset_pkg::d2h_fis_t sig_fis,
  input wire logic                   cmd_abort,
  input wire logic                   hw_reset,
  input wire logic [7:0]             port_enable,
  input wire logic                   in_no_comm,
  input wire logic [3:0]             avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_writedata,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest
);
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Length of the current no-comm stay, cleared outside it
  always_comb cnt_d = in_no_comm ? cnt_q + 6'h01 : 6'h00;
  always_ff @(posedge clk) cnt_q <= rst ? 6'h00 : cnt_d;
  // Soft-reset halves of the host pair
  sequence s_set; h2d_fis.valid && !h2d_fis.is_command && h2d_fis.device_control[2] && !in_no_comm; endsequence
  sequence s_clr; h2d_fis.valid && !h2d_fis.is_command && !h2d_fis.device_control[2]; endsequence
  property p_powerup; $fell(rst) |-> in_no_comm && hw_reset && port_enable == 8'h00 && !sig_fis_valid; endproperty
  property p_nocomm; in_no_comm |-> hw_reset && port_enable == 8'h00 && !sig_fis_valid && !cominit_req; endproperty
  property p_nocomm_len; $fell(in_no_comm) |-> cnt_q >= 6'h0E && cnt_q <= 6'h12; endproperty
  property p_comreset; $rose(comreset_pin) |-> ##[1:8] in_no_comm; endproperty
  property p_sig_fields; sig_fis_valid |-> sig_fis[63:0] == 64'h0096006900010001 && sig_fis.error == 8'h00
    && (sig_fis.status & 8'hEF) == 8'h40; endproperty
  property p_sig_hold; sig_fis_valid && !sig_fis_ready |=> sig_fis_valid || in_no_comm; endproperty
  property p_sig_once; sig_fis_valid && sig_fis_ready |=> !sig_fis_valid; endproperty
  property p_sig_cause; s_set ##[1:20] s_clr |=> sig_fis_valid; endproperty
  property p_abort; h2d_fis.valid && h2d_fis.is_command && h2d_fis.command == 8'h08 && !in_no_comm
    |=> cmd_abort && !in_no_comm; endproperty
  property p_soft_keep; s_set |=> !in_no_comm && port_enable == $past(port_enable); endproperty
  a_powerup: assert property (p_powerup) else $error("no-comm not entered after reset");
  a_nocomm: assert property (p_nocomm) else $error("state not cleared in no-comm");
  a_nocomm_len: assert property (p_nocomm_len) else $error("no-comm stay has wrong length");
  a_comreset: assert property (p_comreset) else $error("comreset ignored");
  a_sig_fields: assert property (p_sig_fields) else $error("signature fields wrong");
  a_sig_hold: assert property (p_sig_hold) else $error("signature dropped before taken");
  a_sig_once: assert property (p_sig_once) else $error("signature sent twice");
  a_sig_cause: assert property (p_sig_cause) else $error("no signature after clear");
  a_abort: assert property (p_abort) else $error("device reset not refused");
  a_soft_keep: assert property (p_soft_keep) else $error("soft reset disturbed state");
endmodule
bind pm_reset_ctrl pm_reset_ctrl_assertions u_pm_reset_ctrl_assertions (.clk, .rst, .comreset_pin, .cominit_req,
  .cominit_sent, .h2d_fis, .sig_fis_valid, .sig_fis_ready, .sig_fis, .cmd_abort, .hw_reset, .port_enable,
  .in_no_comm, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);

// file: bench/host_link_model.sv
// Host controller model on the far side of the link
`timescale 1ns/1ps
module host_link_model (
  input  wire logic              clk,
  input  wire logic              cominit_req,
  input  wire logic              sig_fis_valid,
  output logic                   comreset_pin,
  output logic                   cominit_sent,
  output pm_reset_pkg::h2d_fis_t h2d_fis,
  output logic                   sig_fis_ready
);
  int init_lag = 2;
  int lag      = 0;
  int cw       = 0;
  int w        = 0;
  initial begin
    comreset_pin = 1'b0; cominit_sent = 1'b0; h2d_fis = '0; sig_fis_ready = 1'b0;
  end
  // COMINIT goes out after a settable link delay; a long delay opens the early-reset window
  always @(posedge clk) begin
    cominit_sent <= cominit_req && !cominit_sent && cw >= init_lag;
    cw <= (cominit_req && !cominit_sent && cw < init_lag) ? cw + 1 : 0;
  end
  // Signature taken after a settable stall
  always @(posedge clk) begin
    sig_fis_ready <= sig_fis_valid && !sig_fis_ready && w >= lag;
    w <= (sig_fis_valid && !sig_fis_ready) ? w + 1 : 0;
  end
  // The only way the host resets the multiplier; held past the pin filter
  task comreset();
    comreset_pin <= 1'b1;
    repeat (6) @(posedge clk);
    comreset_pin <= 1'b0;
    @(posedge clk);
  endtask
  // One register FIS; idle fields are inverted so stale values never look valid
  task send(input logic c, input logic [7:0] cm, input logic [7:0] dc);
    h2d_fis <= '{1'b1, c, cm, dc};
    @(posedge clk);
    h2d_fis <= '{1'b0, ~c, ~cm, ~dc};
    @(posedge clk);
  endtask
  // Soft reset: set FISes, then one clear FIS
  task soft_reset(input int sets);
    repeat (sets) send(1'b0, 8'h00, 8'h04);
    send(1'b0, 8'h00, 8'h00);
  endtask
endmodule

// file: bench/port_multiplier_reset_control_tb.sv
// Self-checking bench for the reset and soft-reset controller
`timescale 1ns/1ps
module port_multiplier_reset_control_tb;
  logic                   clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, pv;
  logic                   cominit_req, cominit_sent, comreset_pin, sig_fis_valid, sig_fis_ready;
  logic                   cmd_abort, hw_reset, in_no_comm, avs_waitrequest;
  logic [3:0]             avs_address = 4'h0;
  logic [31:0]            avs_writedata = 32'h0, avs_readdata, q;
  logic [7:0]             port_enable;
  pm_reset_pkg::h2d_fis_t h2d_fis;
  pm_reset_pkg::d2h_fis_t sig_fis;
  int                     fails = 0, compares = 0, n;
  pm_reset_ctrl u_pm_reset_ctrl (.clk, .rst, .comreset_pin, .cominit_req, .cominit_sent, .h2d_fis, .sig_fis_valid,
    .sig_fis_ready, .sig_fis, .cmd_abort, .hw_reset, .port_enable, .in_no_comm, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest);
  host_link_model u_host_link_model (.clk, .cominit_req, .sig_fis_valid, .comreset_pin, .cominit_sent, .h2d_fis,
    .sig_fis_ready);
  initial begin
    forever #20 clk = ~clk;
  end
  task chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One Avalon access; request held until waitrequest is sampled low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a; avs_writedata <= d; avs_write <= wr; avs_read <= !wr;
    n = 0;
    do begin @(posedge clk); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    chk("bus_answer", avs_waitrequest, 1'b0);
    avs_read <= 1'b0; avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task wait_up();
    n = 0;
    while (in_no_comm !== 1'b0 && n < 40) begin @(posedge clk); n++; end
  endtask
  task t_powerup();
    chk("no_comm", in_no_comm, 1'b1);
    chk("hw_reset", hw_reset, 1'b1);
    chk("ports_off", port_enable, 8'h00);
    wait_up();
    chk("seq_len_ok", n >= 14 && n <= 18, 1'b1);
    repeat (6) @(posedge clk);
    bus(1'b0, pm_reset_pkg::ADDR_STATUS, 32'h0);
    chk("cominit_done", q[9], 1'b1);
  endtask
  // Second reset, then COMRESET while the first COMINIT is still pending
  task t_early();
    u_host_link_model.init_lag = 500;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wait_up();
    chk("cominit_pending", cominit_req, 1'b1);
    u_host_link_model.comreset();
    chk("early_comreset", in_no_comm, 1'b1);
    bus(1'b0, pm_reset_pkg::ADDR_EVENTS, 32'h0);
    chk("comreset_event", q[0], 1'b1);
    bus(1'b1, pm_reset_pkg::ADDR_EVENTS, 32'h1);
    bus(1'b0, pm_reset_pkg::ADDR_EVENTS, 32'h0);
    chk("event_cleared", q[0], 1'b0);
    u_host_link_model.init_lag = 2;
    wait_up();
  endtask
  task t_ports();
    bus(1'b1, pm_reset_pkg::ADDR_PORT_EN, 32'hA5);
    chk("port_en_set", port_enable, 8'hA5);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped", q, 32'h0);
    u_host_link_model.comreset();
    chk("ports_cleared", port_enable, 8'h00);
    bus(1'b1, pm_reset_pkg::ADDR_PORT_EN, 32'hFF);
    bus(1'b0, pm_reset_pkg::ADDR_PORT_EN, 32'h0);
    chk("port_en_locked", q, 32'h0);
    wait_up();
  endtask
  task t_soft();
    bus(1'b1, pm_reset_pkg::ADDR_PORT_EN, 32'h5A);
    u_host_link_model.send(1'b0, 8'h00, 8'h00);
    repeat (4) @(posedge clk);
    chk("clear_alone", sig_fis_valid, 1'b0);
    u_host_link_model.lag = 3;
    u_host_link_model.soft_reset(2);
    chk("sig_valid", sig_fis_valid, 1'b1);
    chk("sig_lba_count", sig_fis[63:0], 64'h0096006900010001);
    chk("sig_error", sig_fis.error, 8'h00);
    chk("sig_status", sig_fis.status & 8'hEF, 8'h40);
    chk("soft_ports", port_enable, 8'h5A);
    chk("soft_no_comm", in_no_comm, 1'b0);
    n = 0;
    pv = 1'b1;
    repeat (20) begin
      @(posedge clk);
      if (sig_fis_valid !== 1'b0 && !pv) n++;
      pv = sig_fis_valid;
    end
    chk("sig_count", {n, sig_fis_valid}, 33'h0);
    bus(1'b0, pm_reset_pkg::ADDR_EVENTS, 32'h0);
    chk("sig_event", q[1], 1'b1);
  endtask
  task t_dev();
    u_host_link_model.send(1'b1, pm_reset_pkg::CMD_DEVICE_RESET, 8'h00);
    chk("abort", cmd_abort, 1'b1);
    chk("dev_ports", {in_no_comm, port_enable}, 9'h05A);
    bus(1'b0, pm_reset_pkg::ADDR_EVENTS, 32'h0);
    chk("refuse_event", q[2], 1'b1);
  endtask
  task complete_run();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Hang guard, well beyond the few hundred cycles the tests need
  initial begin
    #(40 * 5000);
    fails++;
    complete_run();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_powerup();
    t_early();
    t_ports();
    t_soft();
    t_dev();
    complete_run();
  end
endmodule
